// File: cfsp_pkg.sv
// ****************************************
// Serial frame port constants and types
// ****************************************
package cfsp_pkg;
    // AXI4-Lite register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DAC = 8'h08;
    localparam logic [7:0] OFS_ADC = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'h0;
    localparam logic [15:0] ADC_RST = 16'h0000;
    // Frame timing in shift-clock periods; divider phases in master clocks
    localparam logic [6:0] PERIOD_DEF = 7'h7F;
    localparam logic [6:0] SLOT_PRI = 7'h00;
    localparam logic [6:0] SEC_SLOT_DEF = 7'h20;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [3:0] HDR_BITS = 4'h7;
    localparam logic [1:0] DIV_RISE = 2'h1;
    localparam logic [1:0] DIV_FALL = 2'h3;
    // Codec register file
    localparam int CODEC_REGS = 32;
    localparam logic [4:0] REG_NO_OP = 5'h00;
    localparam logic [4:0] REG_CTRL1 = 5'h01;
    localparam logic [4:0] REG_CTRL2 = 5'h02;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int WLEN_BIT_DEF = 0;
    localparam int FLAGA_BIT = 0;
    localparam int FLAGB_BIT = 1;
    localparam int PHONE_BIT = 6;
    localparam int ALT_BIT = 7;

    typedef struct packed {
        logic [1:0] spare;
        logic readNotWrite;
        logic [4:0] addr;
        logic [7:0] data;
    } cfsp_sec_word_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PRI = 3'b010,
        ST_SEC = 3'b100
    } cfsp_state_t;
endpackage

// File: cfsp_codec_serial_frame_port.sv
`timescale 1ns/100ps
// Behaviour
// - Primary input is DAC; secondary is control.
// - Request pin sampled half clock after primary frame.
// - Shifting starts at frame sync fall.
// - Sync falls on shift rise, low 16 bits.
// - Primary every period; secondary only on request.
// - Reset selects 15-bit mode with control bit.
// - 16-bit mode uses all bits as DAC.
// - MSB first; D0 control in 15-bit mode.
// - Samples are two's complement both ways.
// - Primary frame exchanges one word each way.
// - ADC word always sixteen bits.
// - Request by pin or, in 15-bit mode, by primary LSB.
// - In 15-bit mode, primary D0 one requests secondary frame.
// - Secondary sync 32 periods after primary start.
// - Secondary write returns zero word.
// - Secondary read returns addressed register; in phone mode CTRL2 bit 7 is alternate status.
// - Read ignores the low eight input bits.
// - Read flag D13, address D12-D8, data D7-D0.
// - Register zero is a no operation.
// - One register per secondary frame.
// - Shift clock is master clock over four.
// - Phone mode flags and alternate status report.
// - Data output released on seventeenth rise.
// - DAC word captured on seventeenth rise.
// - Register data applied at sync rise.
// - Read word upper byte zero; else zeros.
module cfsp_codec_serial_frame_port #(
    parameter int WLEN_BIT = cfsp_pkg::WLEN_BIT_DEF,
    parameter logic [6:0] PERIOD = cfsp_pkg::PERIOD_DEF,
    parameter logic [6:0] SEC_SLOT = cfsp_pkg::SEC_SLOT_DEF
) (
    // Clock, reset, enable
    input logic clk_sys,
    input logic sys_rst,
    input logic clkEn,
    // AXI4-Lite write
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Serial pins
    output logic shiftClock,
    output logic frameSyncN,
    output logic serialDataOut,
    output logic serialDataOutEn,
    input logic serialDataIn,
    input logic functionControlRequest,
    // Phone mode pins
    input logic alternateStatusInput,
    output logic hostOutputA,
    output logic hostOutputB
);
    // ****************************************
    // State
    // ****************************************
    logic [1:0] divQ;
    logic [6:0] slotQ;
    cfsp_pkg::cfsp_state_t stateQ;
    logic [3:0] bitQ;
    logic [3:0] inCntQ;
    logic [15:0] inSrQ;
    logic [15:0] outSrQ;
    logic syncNQ;
    logic doutQ;
    logic doutEnQ;
    logic pendQ;
    logic reqArmQ;
    logic [7:0] codecRegs [cfsp_pkg::CODEC_REGS];
    logic [15:0] adcWordQ;
    logic [15:0] dacWordQ;
    logic runQ;

    // ****************************************
    // Frame decode
    // ****************************************
    logic sclkRise;
    logic sclkFall;
    logic inFrame;
    logic frameEnd;
    logic priEnd;
    logic secEnd;
    logic startPri;
    logic startSec;
    logic mode16;
    logic phoneMode;
    logic [7:0] hdr;
    logic hdrRead;
    logic [4:0] hdrAddr;
    logic [7:0] rdByte;
    logic [7:0] regVal;
    cfsp_pkg::cfsp_sec_word_t secWord;
    logic secWrite;
    logic swReq;

    assign sclkRise = clkEn && (divQ == cfsp_pkg::DIV_RISE);
    assign sclkFall = clkEn && (divQ == cfsp_pkg::DIV_FALL);
    assign inFrame = (stateQ != cfsp_pkg::ST_IDLE);
    assign frameEnd = sclkRise && inFrame && (bitQ == cfsp_pkg::LAST_BIT);
    assign priEnd = frameEnd && (stateQ == cfsp_pkg::ST_PRI);
    assign secEnd = frameEnd && (stateQ == cfsp_pkg::ST_SEC);
    assign startPri = sclkRise && !inFrame && runQ &&
        (slotQ == cfsp_pkg::SLOT_PRI);
    assign startSec = sclkRise && !inFrame && pendQ &&
        (slotQ == SEC_SLOT);
    assign mode16 = codecRegs[cfsp_pkg::REG_CTRL1][WLEN_BIT];
    assign phoneMode = codecRegs[cfsp_pkg::REG_CTRL2][cfsp_pkg::PHONE_BIT];
    // Upper byte of the secondary word, complete at the eighth sample
    assign hdr = {inSrQ[6:0], serialDataIn};
    assign hdrRead = hdr[5];
    assign hdrAddr = hdr[4:0];
    assign regVal = codecRegs[hdrAddr];
    assign rdByte = !hdrRead ? 8'h00 :
        (phoneMode && hdrAddr == cfsp_pkg::REG_CTRL2) ?
        {alternateStatusInput, regVal[6:0]} : regVal;
    assign secWord = cfsp_pkg::cfsp_sec_word_t'(inSrQ);
    assign secWrite = secEnd && !secWord.readNotWrite &&
        (secWord.addr != cfsp_pkg::REG_NO_OP);
    assign swReq = !mode16 && inSrQ[0];

    // ****************************************
    // Shift clock divider and slot counter
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            divQ <= 2'h0;
            slotQ <= 7'h00;
        end else if (clkEn) begin
            divQ <= divQ + 2'h1;
            if (sclkRise) begin
                slotQ <= (slotQ == PERIOD) ? 7'h00 : slotQ + 7'h01;
            end
        end
    end
    assign shiftClock = divQ[1];

    // ****************************************
    // Frame sequencer
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stateQ <= cfsp_pkg::ST_IDLE;
            bitQ <= 4'h0;
            syncNQ <= 1'b1;
            doutQ <= 1'b0;
            doutEnQ <= 1'b0;
            outSrQ <= 16'h0000;
        end else if (startPri || startSec) begin
            stateQ <= startPri ? cfsp_pkg::ST_PRI : cfsp_pkg::ST_SEC;
            bitQ <= 4'h0;
            syncNQ <= 1'b0;
            doutEnQ <= 1'b1;
            doutQ <= startPri ? adcWordQ[15] : 1'b0;
            outSrQ <= startPri ? {adcWordQ[14:0], 1'b0} : 16'h0000;
        end else if (frameEnd) begin
            stateQ <= cfsp_pkg::ST_IDLE;
            syncNQ <= 1'b1;
            doutEnQ <= 1'b0;
            doutQ <= 1'b0;
        end else if (sclkRise && inFrame) begin
            bitQ <= bitQ + 4'h1;
            doutQ <= outSrQ[15];
            outSrQ <= {outSrQ[14:0], 1'b0};
        end else if (sclkFall && stateQ == cfsp_pkg::ST_SEC &&
                inCntQ == cfsp_pkg::HDR_BITS) begin
            outSrQ <= {rdByte, 8'h00};
        end
    end
    assign frameSyncN = syncNQ;
    assign serialDataOut = doutQ;
    assign serialDataOutEn = doutEnQ;

    // ****************************************
    // Input shifter and request capture
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            inSrQ <= 16'h0000;
            inCntQ <= 4'h0;
            dacWordQ <= 16'h0000;
            pendQ <= 1'b0;
            reqArmQ <= 1'b0;
        end else if (clkEn) begin
            if (startPri || startSec) begin
                inCntQ <= 4'h0;
            end else if (sclkFall && inFrame) begin
                inSrQ <= {inSrQ[14:0], serialDataIn};
                inCntQ <= inCntQ + 4'h1;
            end
            if (startSec) begin
                pendQ <= 1'b0;
            end
            if (priEnd) begin
                dacWordQ <= mode16 ? inSrQ : {inSrQ[15:1], 1'b0};
                reqArmQ <= 1'b1;
                if (swReq) begin
                    pendQ <= 1'b1;
                end
            end
            if (sclkFall && reqArmQ) begin
                reqArmQ <= 1'b0;
                if (functionControlRequest) begin
                    pendQ <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Codec register file
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < cfsp_pkg::CODEC_REGS; i++) begin
                codecRegs[i] <= cfsp_pkg::REG_RST;
            end
        end else if (clkEn && secWrite) begin
            codecRegs[secWord.addr] <= secWord.data;
        end
    end
    assign hostOutputA = phoneMode &&
        codecRegs[cfsp_pkg::REG_CTRL2][cfsp_pkg::FLAGA_BIT];
    assign hostOutputB = phoneMode &&
        codecRegs[cfsp_pkg::REG_CTRL2][cfsp_pkg::FLAGB_BIT];

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic awHeldQ;
    logic wHeldQ;
    logic [7:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic bvalidQ;
    logic [1:0] brespQ;
    logic rvalidQ;
    logic [31:0] rdataQ;
    logic [1:0] rrespQ;
    logic doWrite;
    logic wrHit;
    logic rdHit;
    logic [31:0] rdMux;
    logic [31:0] statusWord;

    assign s_axi_awready = clkEn && !awHeldQ && !bvalidQ;
    assign s_axi_wready = clkEn && !wHeldQ && !bvalidQ;
    assign s_axi_arready = clkEn && !rvalidQ;
    assign doWrite = clkEn && awHeldQ && wHeldQ;
    assign wrHit = (awAddrQ == cfsp_pkg::OFS_CTRL) ||
        (awAddrQ == cfsp_pkg::OFS_ADC);
    assign statusWord = {26'h000_0000, stateQ, phoneMode, pendQ, mode16};
    assign rdHit = (s_axi_araddr == cfsp_pkg::OFS_CTRL) ||
        (s_axi_araddr == cfsp_pkg::OFS_STATUS) ||
        (s_axi_araddr == cfsp_pkg::OFS_DAC) ||
        (s_axi_araddr == cfsp_pkg::OFS_ADC);
    assign rdMux =
        (s_axi_araddr == cfsp_pkg::OFS_CTRL) ? {31'h0000_0000, runQ} :
        (s_axi_araddr == cfsp_pkg::OFS_STATUS) ? statusWord :
        (s_axi_araddr == cfsp_pkg::OFS_DAC) ? {16'h0000, dacWordQ} :
        (s_axi_araddr == cfsp_pkg::OFS_ADC) ? {16'h0000, adcWordQ} :
        32'h0000_0000;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0000_0000;
            wStrbQ <= 4'h0;
            bvalidQ <= 1'b0;
            brespQ <= cfsp_pkg::RESP_OKAY;
            runQ <= cfsp_pkg::CTRL_RUN_RST;
            adcWordQ <= cfsp_pkg::ADC_RST;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeldQ <= 1'b0;
                wHeldQ <= 1'b0;
                bvalidQ <= 1'b1;
                brespQ <= wrHit ? cfsp_pkg::RESP_OKAY :
                    cfsp_pkg::RESP_DECERR;
                if (awAddrQ == cfsp_pkg::OFS_CTRL && wStrbQ[0]) begin
                    runQ <= wDataQ[cfsp_pkg::CTRL_RUN_BIT];
                end
                if (awAddrQ == cfsp_pkg::OFS_ADC) begin
                    if (wStrbQ[0]) begin
                        adcWordQ[7:0] <= wDataQ[7:0];
                    end
                    if (wStrbQ[1]) begin
                        adcWordQ[15:8] <= wDataQ[15:8];
                    end
                end
            end else if (bvalidQ && s_axi_bready) begin
                bvalidQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rvalidQ <= 1'b0;
            rdataQ <= 32'h0000_0000;
            rrespQ <= cfsp_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalidQ <= 1'b1;
                rdataQ <= rdMux;
                rrespQ <= rdHit ? cfsp_pkg::RESP_OKAY :
                    cfsp_pkg::RESP_DECERR;
            end else if (rvalidQ && s_axi_rready) begin
                rvalidQ <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalidQ;
    assign s_axi_bresp = brespQ;
    assign s_axi_rvalid = rvalidQ;
    assign s_axi_rdata = rdataQ;
    assign s_axi_rresp = rrespQ;

    // ****************************************
    // Checks
    // ****************************************
    logic [4:0] lowRisesQ;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lowRisesQ <= 5'h00;
        end else if (syncNQ) begin
            lowRisesQ <= 5'h00;
        end else if (sclkRise) begin
            lowRisesQ <= lowRisesQ + 5'h01;
        end
    end

    property p_sync_width;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(frameSyncN) |-> (lowRisesQ == 5'h10);
    endproperty
    a_sync_width: assert property (p_sync_width)
        else $error("frame sync low width wrong");

    property p_sync_on_rise;
        @(posedge clk_sys) disable iff (sys_rst)
        $changed(frameSyncN) |-> $rose(shiftClock);
    endproperty
    a_sync_on_rise: assert property (p_sync_on_rise)
        else $error("frame sync moved off shift rise");

    property p_idle_release;
        @(posedge clk_sys) disable iff (sys_rst)
        frameSyncN |-> !serialDataOutEn;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data out driven outside frame");

    property p_drive_start;
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(frameSyncN) |-> serialDataOutEn;
    endproperty
    a_drive_start: assert property (p_drive_start)
        else $error("data out not driven at frame start");

    property p_sclk_div;
        @(posedge clk_sys) disable iff (sys_rst)
        ($rose(shiftClock) || $fell(shiftClock)) && clkEn |=>
            $stable(shiftClock);
    endproperty
    a_sclk_div: assert property (p_sclk_div)
        else $error("shift clock not master over four");

    property p_frame_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(frameSyncN) |->
            (slotQ == 7'h01) || (slotQ == SEC_SLOT + 7'h01);
    endproperty
    a_frame_slot: assert property (p_frame_slot)
        else $error("frame started in wrong slot");

    property p_sec_upper_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        (stateQ == cfsp_pkg::ST_SEC) && serialDataOutEn &&
            (bitQ < 4'h8) |-> !serialDataOut;
    endproperty
    a_sec_upper_zero: assert property (p_sec_upper_zero)
        else $error("secondary upper byte not zero");

    property p_reg_apply;
        @(posedge clk_sys) disable iff (sys_rst)
        secWrite && clkEn |=>
            codecRegs[$past(secWord.addr)] == $past(secWord.data);
    endproperty
    a_reg_apply: assert property (p_reg_apply)
        else $error("secondary write not applied");

    property p_no_op_keep;
        @(posedge clk_sys) disable iff (sys_rst)
        secEnd && (secWord.addr == cfsp_pkg::REG_NO_OP ||
            secWord.readNotWrite) |=> $stable(mode16) && $stable(phoneMode);
    endproperty
    a_no_op_keep: assert property (p_no_op_keep)
        else $error("register changed by no-op or read");

    property p_pin_capture;
        @(posedge clk_sys) disable iff (sys_rst)
        sclkFall && reqArmQ && functionControlRequest |=> pendQ;
    endproperty
    a_pin_capture: assert property (p_pin_capture)
        else $error("request pin not captured");

    property p_sw_request;
        @(posedge clk_sys) disable iff (sys_rst)
        priEnd && swReq |=> pendQ;
    endproperty
    a_sw_request: assert property (p_sw_request)
        else $error("embedded request not captured");

    property p_cov_pri;
        @(posedge clk_sys) disable iff (sys_rst)
        priEnd;
    endproperty
    c_cov_pri: cover property (p_cov_pri);

    property p_cov_sec_write;
        @(posedge clk_sys) disable iff (sys_rst)
        secWrite;
    endproperty
    c_cov_sec_write: cover property (p_cov_sec_write);

    property p_cov_sec_read;
        @(posedge clk_sys) disable iff (sys_rst)
        secEnd && secWord.readNotWrite;
    endproperty
    c_cov_sec_read: cover property (p_cov_sec_read);

    property p_cov_pin;
        @(posedge clk_sys) disable iff (sys_rst)
        sclkFall && reqArmQ && functionControlRequest;
    endproperty
    c_cov_pin: cover property (p_cov_pin);
endmodule // cfsp_codec_serial_frame_port

// File: cfsp_host_port_model.sv
`timescale 1ns/100ps
module cfsp_host_port_model (
    // Clock
    input wire logic clk_sys,
    // Device serial pins
    input wire logic shiftClock,
    input wire logic frameSyncN,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn,
    output logic serialDataIn = 1'b0,
    // Words sent and seen
    input wire logic [15:0] priWord,
    input wire logic [15:0] secWord,
    output logic [15:0] rxWord = 16'h0000,
    output logic [7:0] gap = 8'h00,
    output logic [4:0] nBits = 5'h00,
    output int priCount = 0,
    output int secCount = 0
);
    logic sclkQ = 1'b0;
    logic inFrame = 1'b0;
    logic isSec = 1'b0;
    logic [15:0] txWord = 16'h0000;
    logic [15:0] word;
    logic [7:0] rises = 8'hFF;
    logic [3:0] idx = 4'h0;

    // ********
    // Host side of the link
    // ********
    // Short gap since last frame start marks a secondary frame
    always @(posedge clk_sys) begin
        sclkQ <= shiftClock;
        if (shiftClock && !sclkQ) begin
            if (rises != 8'hFF) begin
                rises <= rises + 8'h01;
            end
            if (!frameSyncN && !inFrame) begin
                word = (rises < 8'h40) ? secWord : priWord;
                txWord <= word;
                isSec <= rises < 8'h40;
                gap <= rises;
                rises <= 8'h01;
                inFrame <= 1'b1;
                nBits <= 5'h00;
                idx <= 4'h1;
                serialDataIn <= word[15];
            end else if (!frameSyncN) begin
                serialDataIn <= txWord[4'hF - idx];
                idx <= idx + 4'h1;
            end else if (inFrame) begin
                // Released line shows the inverse of the last bit
                inFrame <= 1'b0;
                serialDataIn <= ~serialDataIn;
                if (isSec) begin
                    secCount <= secCount + 1;
                end else begin
                    priCount <= priCount + 1;
                end
            end
        end
        if (!shiftClock && sclkQ && inFrame && !frameSyncN) begin
            rxWord <= {rxWord[14:0],
                serialDataOutEn ? serialDataOut : ~serialDataOut};
            nBits <= nBits + 5'h01;
        end
    end
endmodule // cfsp_host_port_model

// File: cfsp_codec_serial_frame_port_test.sv
`timescale 1ns/100ps
module cfsp_codec_serial_frame_port_test;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic functionControlRequest = 1'b0, alternateStatusInput = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, shiftClock, frameSyncN, serialDataOut;
    logic serialDataOutEn, serialDataIn, hostOutputA, hostOutputB;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic sclkHeld;
    logic [15:0] priWord = 16'h0000, secWord = 16'h0000, rxWord;
    logic [7:0] gap;
    logic [4:0] nBits;
    int priCount, secCount, c;
    int miscompares = 0, nCompared = 0;
    logic [15:0] secTab [7] = '{16'h0243, 16'h22FF, 16'h00FF, 16'h2000,
        16'h0201, 16'h2200, 16'h0101};
    logic [15:0] rxTab [7] = '{16'h0000, 16'h00C3, 16'h0000, 16'h0000,
        16'h0000, 16'h0001, 16'h0000};
    logic [1:0] flagTab [7] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};

    always #20 clk_sys = ~clk_sys;

    cfsp_codec_serial_frame_port dut (.clk_sys, .sys_rst, .clkEn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .shiftClock, .frameSyncN, .serialDataOut,
        .serialDataOutEn, .serialDataIn, .functionControlRequest,
        .alternateStatusInput, .hostOutputA, .hostOutputB);

    cfsp_host_port_model host (.clk_sys, .shiftClock, .frameSyncN,
        .serialDataOut, .serialDataOutEn, .serialDataIn, .priWord,
        .secWord, .rxWord, .gap, .nBits, .priCount, .secCount);

    // ********
    // Tasks
    // ********
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
            miscompares++;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, bd;
        logic [1:0] r;
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            bd = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end while (!bd && n < 50);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
        chk("bvalid", 32'h1, 32'(bd));
        chk("bresp", 32'(er), 32'(r));
    endtask

    task rdChk(input string what, input logic [7:0] a,
        input logic [31:0] e, input logic [1:0] er);
        logic ta, tv;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_arvalid && s_axi_arready;
            tv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
            n++;
        end while (!tv && n < 50);
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
        chk("rvalid", 32'h1, 32'(tv));
        chk(what, e, d);
        chk("rresp", 32'(er), 32'(r));
    endtask

    task frame(input logic sec, input logic [15:0] e);
        int c0, n;
        c0 = sec ? secCount : priCount;
        n = 0;
        while ((sec ? secCount : priCount) == c0 && n < 1500) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (2) @(posedge clk_sys);
        chk("frame seen", 32'h0, 32'(n >= 1500));
        chk(sec ? "secondary word" : "primary word", 32'(e), 32'(rxWord));
        chk("frame bits", 32'h10, 32'(nBits));
        chk("idle pins", 32'h2, 32'({frameSyncN, serialDataOutEn}));
        if (sec) chk("secondary gap", 32'h20, 32'(gap));
    endtask

    task completeRun;
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rdChk("ctrl", cfsp_pkg::OFS_CTRL, 32'h0000_0000, 2'h0);
        rdChk("status", cfsp_pkg::OFS_STATUS, 32'h0000_0008, 2'h0);
        rdChk("unmapped", 8'h10, 32'h0000_0000, cfsp_pkg::RESP_DECERR);
        wr(cfsp_pkg::OFS_STATUS, 32'h0000_0001, cfsp_pkg::RESP_DECERR);
        chk("idle pins", 32'h2, 32'({frameSyncN, serialDataOutEn}));
        clkEn <= 1'b0;
        @(posedge clk_sys);
        sclkHeld = shiftClock;
        repeat (6) @(posedge clk_sys);
        chk("frozen shift clock", 32'(sclkHeld), 32'(shiftClock));
        chk("frozen arready", 32'h0, 32'(s_axi_arready));
        clkEn <= 1'b1;
        @(posedge clk_sys);
        $display("test reset ended");
        priWord <= 16'hA5A4;
        wr(cfsp_pkg::OFS_ADC, 32'h0000_8001, cfsp_pkg::RESP_OKAY);
        wr(cfsp_pkg::OFS_CTRL, 32'h0000_0001, cfsp_pkg::RESP_OKAY);
        frame(1'b0, 16'h8001);
        c = secCount;
        frame(1'b0, 16'h8001);
        chk("secondary count", 32'(c), 32'(secCount));
        rdChk("dac", cfsp_pkg::OFS_DAC, 32'h0000_A5A4, 2'h0);
        $display("test primary ended");
        for (int i = 0; i < 7; i++) begin
            priWord <= 16'h1235;
            secWord <= secTab[i];
            frame(1'b0, 16'h8001);
            rdChk("dac", cfsp_pkg::OFS_DAC, 32'h0000_1234, 2'h0);
            priWord <= 16'h1234;
            frame(1'b1, rxTab[i]);
            chk("flags", 32'(flagTab[i]),
                32'({hostOutputA, hostOutputB}));
        end
        $display("test secondary ended");
        c = secCount;
        priWord <= 16'h1235;
        frame(1'b0, 16'h8001);
        frame(1'b0, 16'h8001);
        chk("secondary count", 32'(c), 32'(secCount));
        rdChk("dac", cfsp_pkg::OFS_DAC, 32'h0000_1235, 2'h0);
        rdChk("status", cfsp_pkg::OFS_STATUS, 32'h0000_0009, 2'h0);
        functionControlRequest <= 1'b1;
        secWord <= 16'h0243;
        frame(1'b0, 16'h8001);
        repeat (8) @(posedge clk_sys);
        functionControlRequest <= 1'b0;
        frame(1'b1, 16'h0000);
        chk("flags", 32'h3, 32'({hostOutputA, hostOutputB}));
        alternateStatusInput <= 1'b0;
        functionControlRequest <= 1'b1;
        secWord <= 16'h22FF;
        frame(1'b0, 16'h8001);
        functionControlRequest <= 1'b0;
        frame(1'b1, 16'h0043);
        $display("test request pin ended");
        completeRun();
    end

    initial begin
        #(40 * 40000);
        miscompares++;
        $display("CHECK FAILED watchdog expected end seen hang");
        completeRun();
    end
endmodule // cfsp_codec_serial_frame_port_test
